// ===== plsc_pkg.sv
// Purpose: Constants for the phase locked speed controller core
// Assumes: Single clock domain, oscillator clock drives all logic
// Notes:   Three-level select encoded as two bits on the ports
package plsc_pkg;
  // ==========================================================
  // Prescaler selects and ratios
  // ==========================================================
  localparam logic [1:0] SEL2_LOW = 2'h0;
  localparam logic [1:0] SEL2_MID = 2'h1;
  localparam logic [1:0] SEL2_HIGH = 2'h2;
  localparam logic [2:0] DIV1_HIGH_RATIO = 3'h4;
  localparam logic [2:0] DIV1_LOW_RATIO = 3'h5;
  localparam logic [3:0] DIV2_LOW_RATIO = 4'h2;
  localparam logic [3:0] DIV2_MID_RATIO = 4'h4;
  localparam logic [3:0] DIV2_HIGH_RATIO = 4'h8;
  localparam logic [2:0] CNT1_RESET = 3'h0;
  localparam logic [3:0] CNT2_RESET = 4'h0;
  // ==========================================================
  // Phase detector states
  // ==========================================================
  typedef enum logic [1:0] {
    PD_DOWN    = 2'b00,
    PD_NEUTRAL = 2'b01,
    PD_UP      = 2'b10
  } plsc_pd_state_t;
endpackage

// ===== plsc_divider.sv
// Purpose: Programmable divide-by-N stage with one-cycle tick out
// Assumes: Ratio at least two
// Notes:   Ratio latched only at cycle boundary
`timescale 1ns/1ps
module plsc_divider #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Divider control
  input  wire logic         en,
  input  wire logic [W-1:0] ratio,
  // Output
  output logic              tick_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] ratio_q;

  // ==========================================================
  // Counter, ratio reloads only on wrap
  // ==========================================================
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= '0;
      ratio_q <= W'(2);
      tick_q  <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (en) begin
        if (cnt_q >= ratio_q - W'(1)) begin
          cnt_q   <= '0;
          ratio_q <= ratio;
          tick_q  <= 1'b1;
        end else begin
          cnt_q <= cnt_q + W'(1);
        end
      end
    end
  end
endmodule

// ===== plsc_core.sv
// Purpose: Reference dividers, sense edge detect, phase detector, lock flag
// Assumes: Sense input already squared and synchronous to clock
// Notes:   Reference is a one-cycle tick per divided period
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Select one high: first stage divides four
// RULE_02 - Select one low: first stage divides five
// RULE_03 - Select two: low two, mid four, high eight
// RULE_04 - Reference equals oscillator over total ratio
// RULE_05 - Double-edge select high disables, low enables
// RULE_06 - Double-edge: event on both sense edges
// RULE_07 - Equal frequency: output tracks phase difference
// RULE_08 - Frequency error: output saturates correcting direction
// RULE_09 - Lock asserted only without frequency error; code clears lock_q only when an edge repeats
// RULE_10 - Three-state detector; repeated edge drops lock
// RULE_11 - Select changes apply at divider boundary
module plsc_core (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Configuration
  input  wire logic       div1_sel,
  input  wire logic [1:0] div2_sel,
  input  wire logic       dbl_edge_dis,
  // Feedback
  input  wire logic       sense_in,
  // Outputs
  output logic            ref_q,
  output logic            pump_up_q,
  output logic            pump_down_q,
  output logic            lock_q
);
  logic [2:0]               ratio1;
  logic [3:0]               ratio2;
  logic                     tick1;
  logic                     tick2;
  logic                     sense_q;
  logic                     dbl_en_q;
  logic                     fb_ev;
  logic                     last_ref_q;
  logic                     last_fb_q;
  plsc_pkg::plsc_pd_state_t state_q;

  // ==========================================================
  // Prescaler ratios
  // ==========================================================
  assign ratio1 = div1_sel ? plsc_pkg::DIV1_HIGH_RATIO    // see RULE_01
                           : plsc_pkg::DIV1_LOW_RATIO;    // see RULE_02
  always_comb begin
    case (div2_sel)                                       // see RULE_03
      plsc_pkg::SEL2_LOW:  ratio2 = plsc_pkg::DIV2_LOW_RATIO;
      plsc_pkg::SEL2_MID:  ratio2 = plsc_pkg::DIV2_MID_RATIO;
      plsc_pkg::SEL2_HIGH: ratio2 = plsc_pkg::DIV2_HIGH_RATIO;
      default:             ratio2 = plsc_pkg::DIV2_MID_RATIO;
    endcase
  end

  // Cascade, ratios latched at wrap; see RULE_04 see RULE_11
  plsc_divider #(.W(3)) u_div1 (
    .clock  (clock),
    .nrst   (nrst),
    .en     (1'b1),
    .ratio  (ratio1),
    .tick_q (tick1)
  );
  plsc_divider #(.W(4)) u_div2 (
    .clock  (clock),
    .nrst   (nrst),
    .en     (tick1),
    .ratio  (ratio2),
    .tick_q (tick2)
  );

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= tick2;
    end
  end

  // ==========================================================
  // Sense edge detection
  // ==========================================================
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sense_q  <= 1'b0;
      dbl_en_q <= 1'b0;
    end else begin
      sense_q <= sense_in;
      if (tick2) begin
        dbl_en_q <= !dbl_edge_dis;                         // see RULE_05 see RULE_11
      end
    end
  end

  assign fb_ev = dbl_en_q ? (sense_in ^ sense_q)           // see RULE_06
                          : (sense_in & !sense_q);

  // ==========================================================
  // Phase frequency detector
  // ==========================================================
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= plsc_pkg::PD_NEUTRAL;
    end else if (ref_q && fb_ev) begin
      state_q <= plsc_pkg::PD_NEUTRAL;                     // see RULE_07
    end else if (ref_q && !fb_ev) begin                    // see RULE_10
      case (state_q)
        plsc_pkg::PD_DOWN:    state_q <= plsc_pkg::PD_NEUTRAL;
        plsc_pkg::PD_NEUTRAL: state_q <= plsc_pkg::PD_UP;
        plsc_pkg::PD_UP:      state_q <= plsc_pkg::PD_UP;  // see RULE_08
        default:              state_q <= plsc_pkg::PD_NEUTRAL;
      endcase
    end else if (fb_ev && !ref_q) begin
      case (state_q)
        plsc_pkg::PD_UP:      state_q <= plsc_pkg::PD_NEUTRAL;
        plsc_pkg::PD_NEUTRAL: state_q <= plsc_pkg::PD_DOWN;
        plsc_pkg::PD_DOWN:    state_q <= plsc_pkg::PD_DOWN; // see RULE_08
        default:              state_q <= plsc_pkg::PD_NEUTRAL;
      endcase
    end
  end

  // Pump outputs width tracks phase lag; see RULE_07
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pump_up_q   <= 1'b0;
      pump_down_q <= 1'b0;
    end else begin
      pump_up_q   <= (state_q == plsc_pkg::PD_UP);
      pump_down_q <= (state_q == plsc_pkg::PD_DOWN);
    end
  end

  // ==========================================================
  // Lock flag
  // ==========================================================
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      last_ref_q <= 1'b0;
      last_fb_q  <= 1'b0;
      lock_q     <= 1'b0;
    end else if (ref_q && fb_ev) begin
      last_ref_q <= 1'b0;
      last_fb_q  <= 1'b0;
      lock_q     <= !(last_ref_q || last_fb_q);            // see RULE_09 see RULE_10
    end else if (ref_q) begin
      last_ref_q <= 1'b1;
      last_fb_q  <= 1'b0;
      lock_q     <= !last_ref_q;                           // see RULE_09 see RULE_10
    end else if (fb_ev) begin
      last_fb_q  <= 1'b1;
      last_ref_q <= 1'b0;
      lock_q     <= !last_fb_q;                            // see RULE_09 see RULE_10
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence ref_twice_s;
    ref_q && !fb_ev && last_ref_q;
  endsequence

  sequence fb_twice_s;
    fb_ev && !ref_q && last_fb_q;
  endsequence

  sequence both_repeat_s;
    ref_q && fb_ev && (last_ref_q || last_fb_q);
  endsequence

  both_repeat_drop_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_10
    both_repeat_s |=> !lock_q)
    else $error("Lock held after repeated edge with coincident pair");

  coincident_neutral_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_07
    (ref_q && fb_ev) |=> state_q == plsc_pkg::PD_NEUTRAL)
    else $error("Coincident edges did not return detector to neutral");

  ref_double_drop_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_10
    ref_twice_s |=> !lock_q)
    else $error("Lock held after two reference edges");

  fb_double_drop_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_09
    fb_twice_s |=> !lock_q)
    else $error("Lock held after two feedback edges");

  pump_exclusive_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_07
    !(pump_up_q && pump_down_q))
    else $error("Pump up and down together");

  up_saturate_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_08
    (state_q == plsc_pkg::PD_UP && !fb_ev) |=> state_q == plsc_pkg::PD_UP)
    else $error("Up state left without feedback edge");

  down_saturate_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_08
    (state_q == plsc_pkg::PD_DOWN && !ref_q) |=> state_q == plsc_pkg::PD_DOWN)
    else $error("Down state left without reference edge");

  single_edge_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_05
    (!dbl_en_q && $fell(sense_in)) |-> !fb_ev)
    else $error("Falling edge counted in single edge mode");

  double_edge_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_06
    (dbl_en_q && (sense_in != sense_q)) |-> fb_ev)
    else $error("Edge missed in double edge mode");

  div4_period_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_01
    (tick1 && div1_sel && $past(div1_sel, 4) && $past(div1_sel, 8) && $past(nrst, 4)) |-> $past(tick1, 4))
    else $error("First stage not dividing by four");

  div5_period_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_02
    (tick1 && !div1_sel && !$past(div1_sel, 5) && !$past(div1_sel, 10) && $past(nrst, 5)) |-> $past(tick1, 5))
    else $error("First stage not dividing by five");

  ref_follows_a: assert property (@(posedge clock) disable iff (!nrst) // see RULE_04
    tick2 |=> ref_q)
    else $error("Reference tick not delivered");
endmodule

// ===== plsc_sensor_model.sv
// Purpose: Squared speed sensor feedback for the controller core
// Assumes: Output changes just after the rising clock edge
// Notes:   Stopped sensor holds its line low
`timescale 1ns/1ps
module plsc_sensor_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Control
  input  wire logic       en,
  input  wire logic [7:0] half,
  // Feedback
  output logic            sense_q
);
  logic [7:0] cnt_q;

  // ==========================================================
  // Square wave, half period in clock cycles
  // ==========================================================
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= 8'h0;
      sense_q <= 1'b0;
    end else if (!en) begin
      cnt_q   <= 8'h0;
      sense_q <= 1'b0;
    end else if (cnt_q >= half - 8'h1) begin
      cnt_q   <= 8'h0;
      sense_q <= ~sense_q;
    end else begin
      cnt_q <= cnt_q + 8'h1;
    end
  end
endmodule

// ===== plsc_core_test.sv
// Purpose: Self-checking bench for the speed controller core
// Assumes: Clock 250 MHz, reset held three cycles
// Notes:   Outputs sampled on the falling edge
`timescale 1ns/1ps
module plsc_core_test;
  logic        clock, nrst, div1_sel, dbl_edge_dis, sense_in, fb_en;
  logic        ref_q, pump_up_q, pump_down_q, lock_q;
  logic [1:0]  div2_sel;
  logic [7:0]  fb_half;
  logic [15:0] per, ups, dns, lks, r1, r2;
  int          mismatches, total_checks, n;

  plsc_core plsc_core_inst (.clock(clock), .nrst(nrst), .div1_sel(div1_sel), .div2_sel(div2_sel),
    .dbl_edge_dis(dbl_edge_dis), .sense_in(sense_in), .ref_q(ref_q), .pump_up_q(pump_up_q),
    .pump_down_q(pump_down_q), .lock_q(lock_q));
  plsc_sensor_model plsc_sensor_model_inst (.clock(clock), .nrst(nrst), .en(fb_en), .half(fb_half),
    .sense_q(sense_in));

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic period();
    n = 0;
    do begin @(negedge clock); n++; end while (ref_q !== 1'b1 && n < 200);
    per = 16'h0;
    do begin @(negedge clock); per++; end while (ref_q !== 1'b1 && per < 16'd200);
  endtask

  task automatic cfg(input logic d1, input logic [1:0] d2, input logic dis, input logic [7:0] h);
    @(posedge clock);
    div1_sel     <= d1;
    div2_sel     <= d2;
    dbl_edge_dis <= dis;
    fb_en        <= (h != 8'h0);
    fb_half      <= h;
    repeat (5) period();
  endtask

  task automatic observe();
    ups = 16'h0;
    dns = 16'h0;
    lks = 16'h0;
    repeat (64) begin
      @(negedge clock);
      ups += {15'h0, pump_up_q};
      dns += {15'h0, pump_down_q};
      lks += {15'h0, lock_q};
    end
  endtask

  // ==========================================================
  // Clock, reset and watchdog
  // ==========================================================
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    nrst = 1'b0;
    div1_sel = 1'b1;
    div2_sel = 2'h0;
    dbl_edge_dis = 1'b1;
    fb_en = 1'b0;
    fb_half = 8'h0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock);
    check("lock after reset", {15'h0, lock_q}, 16'h0);
    // Every prescaler combination, changed while running
    for (int i = 0; i < 8; i++) begin
      cfg(i[2], i[1:0], 1'b1, 8'h0);
      r1 = i[2] ? 16'(plsc_pkg::DIV1_HIGH_RATIO) : 16'(plsc_pkg::DIV1_LOW_RATIO);
      r2 = (i[1:0] == 2'h0) ? 16'(plsc_pkg::DIV2_LOW_RATIO)
         : (i[1:0] == 2'h2) ? 16'(plsc_pkg::DIV2_HIGH_RATIO) : 16'(plsc_pkg::DIV2_MID_RATIO);
      period();
      check("reference period", per, r1 * r2);
    end
    // No feedback: up saturates, lock drops
    cfg(1'b1, 2'h0, 1'b1, 8'h0);
    observe();
    check("up with no feedback", ups, 16'd64);
    check("lock with no feedback", lks, 16'h0);
    // Matched single edge: rising edge every 8 cycles
    cfg(1'b1, 2'h0, 1'b1, 8'h4);
    observe();
    check("lock when matched", lks, 16'd64);
    check("up not saturated", {15'h0, ups < 16'd64}, 16'h1);
    check("down not saturated", {15'h0, dns < 16'd64}, 16'h1);
    // Double edge: both edges every 8 cycles
    cfg(1'b1, 2'h0, 1'b0, 8'h8);
    observe();
    check("lock double edge", lks, 16'd64);
    // Same sensor single edge: feedback half rate
    cfg(1'b1, 2'h0, 1'b1, 8'h8);
    observe();
    check("no down when slow", dns, 16'h0);
    check("lock lost when slow", {15'h0, lks < 16'd64}, 16'h1);
    // Feedback twice the reference
    cfg(1'b1, 2'h0, 1'b1, 8'h2);
    observe();
    check("no up when fast", ups, 16'h0);
    check("lock lost when fast", {15'h0, lks < 16'd64}, 16'h1);
    print_verdict();
  end
endmodule
